/* File: hw/frs_cfg.svh */
/*
 Timing constants of the fast role swap sequencer, as cycle counts at the core clock.
 Assumes a 250 MHz core clock and that includers guard nothing else themselves.
*/
// Behaviour
// - On the CC swap signal, we send FR_Swap within the initiation deadline.
// - Once VBUS falls below vSafe5V minimum, we supply VBUS within tSrcFRSwap; the code acts on VBUS low only in FRS_ST_TRANSIT, after Accept.
// - Our PS_RDY goes out only after our supply has started.
// - With our PS_RDY we move our CC termination from Rd to Rp.
// - Every swap message is acknowledged by GoodCRC from the receiver.
// - Power negotiation is allowed only after our final PS_RDY is sent.
`ifndef FRS_CFG_SVH
`define FRS_CFG_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define FRS_CLK_MHZ 250
`define FRS_T_FRSWAP_INIT_US 15
`define FRS_T_SRC_FRSWAP_US 150
`define FRS_T_ACK_US 1000
`define FRS_T_RSP_MS 30
`define FRS_FRSWAP_INIT_CYC (`FRS_T_FRSWAP_INIT_US * `FRS_CLK_MHZ)
`define FRS_SRC_FRSWAP_CYC (`FRS_T_SRC_FRSWAP_US * `FRS_CLK_MHZ)
`define FRS_ACK_CYC (`FRS_T_ACK_US * `FRS_CLK_MHZ)
`define FRS_RSP_CYC (`FRS_T_RSP_MS * 1000 * `FRS_CLK_MHZ)
`define FRS_TIMER_W 24
`define FRS_TIMER_RST 24'h0

`endif

/* File: hw/frs_pkg.sv */
/*
 Types of the fast role swap sequencer: messages, states and state records.
 Assumes the protocol layer encodes message kinds as frs_msg_e.
*/
package frs_pkg;

   // ****************************************************************
   // Messages and states
   // ****************************************************************
   typedef enum logic [2:0] {
      FRS_MSG_NONE = 3'h0,
      FRS_MSG_FR_SWAP = 3'h1,
      FRS_MSG_ACCEPT = 3'h2,
      FRS_MSG_PS_RDY = 3'h3,
      FRS_MSG_OTHER = 3'h4
   } frs_msg_e;

   typedef enum logic [2:0] {
      FRS_ST_IDLE = 3'h0,
      FRS_ST_TX_FRSWAP = 3'h1,
      FRS_ST_WAIT_ACCEPT = 3'h2,
      FRS_ST_TRANSIT = 3'h3,
      FRS_ST_TX_PSRDY = 3'h4,
      FRS_ST_SOURCE = 3'h5
   } frs_state_e;

   // ****************************************************************
   // Records
   // ****************************************************************
   typedef struct packed {
      logic frs_detect;
      logic vbus_low;
      logic src_good;
   } frs_pins_s;

   typedef struct packed {
      frs_pins_s meta;
      frs_pins_s stable;
   } frs_sync_s;

   typedef struct packed {
      frs_state_e state;
      logic [23:0] timer;
      logic [23:0] src_timer;
      logic vbus_low_seen;
      logic src_on;
      logic psrdy_rx;
      logic tx_valid;
      frs_msg_e tx_msg;
      logic gcrc_send;
      logic vbus_src_en;
      logic cc_rp_en;
      logic role_src;
      logic negotiate_ok;
      logic swap_error;
   } frs_seq_s;

endpackage : frs_pkg

/* File: hw/frs_sync.sv */
/*
 Two-stage synchroniser for the pin inputs of the sequencer.
 Assumes the pins are levels, stable for several core clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module frs_sync
   import frs_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire frs_pins_s pins_async,
   output frs_pins_s pins_sync
);

   frs_sync_s sync_reg;
   frs_sync_s sync_next;

   always_comb begin
      sync_next.meta = pins_async;
      sync_next.stable = sync_reg.meta;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign pins_sync = sync_reg.stable;

endmodule : frs_sync

`default_nettype wire

/* File: hw/frs_seq.sv */
/*
 Fast role swap sequencer for the initial sink that becomes the new source.
 Assumes a protocol layer on core_clk that sends tx_msg while tx_valid is high and
 answers tx_ack on GoodCRC or tx_nack on failure, and delivers rx_msg with rx_valid.
*/
`timescale 1ns/1ps
`default_nettype none
`include "frs_cfg.svh"

module frs_seq
   import frs_pkg::*;
#(
   parameter int unsigned FRSWAP_INIT_CYC = `FRS_FRSWAP_INIT_CYC,
   parameter int unsigned SRC_FRSWAP_CYC = `FRS_SRC_FRSWAP_CYC,
   parameter int unsigned ACK_CYC = `FRS_ACK_CYC,
   parameter int unsigned RSP_CYC = `FRS_RSP_CYC
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic frs_signal_pin,
   input wire logic vbus_low_pin,
   input wire logic src_good_pin,
   input wire logic tx_ack,
   input wire logic tx_nack,
   input wire logic rx_valid,
   input wire frs_msg_e rx_msg,
   output logic tx_valid,
   output frs_msg_e tx_msg,
   output logic gcrc_send,
   output logic vbus_src_en,
   output logic cc_rp_en,
   output logic role_src,
   output logic negotiate_ok,
   output logic swap_error,
   output frs_state_e seq_state
);

   // ****************************************************************
   // Parameter checks
   // ****************************************************************
   localparam int unsigned TMAX = (1 << `FRS_TIMER_W) - 1;

   if (FRSWAP_INIT_CYC < 2 || FRSWAP_INIT_CYC > TMAX) begin : g_bad_init
      $error("FRSWAP_INIT_CYC out of range");
   end
   if (SRC_FRSWAP_CYC < 2 || SRC_FRSWAP_CYC > TMAX) begin : g_bad_src
      $error("SRC_FRSWAP_CYC out of range");
   end
   if (ACK_CYC < 2 || ACK_CYC > TMAX) begin : g_bad_ack
      $error("ACK_CYC out of range");
   end
   if (RSP_CYC < 2 || RSP_CYC > TMAX) begin : g_bad_rsp
      $error("RSP_CYC out of range");
   end

   localparam logic [23:0] INIT_LD = 24'(FRSWAP_INIT_CYC);
   localparam logic [23:0] SRC_LD = 24'(SRC_FRSWAP_CYC);
   localparam logic [23:0] ACK_LD = 24'(ACK_CYC);
   localparam logic [23:0] RSP_LD = 24'(RSP_CYC);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   frs_pins_s pins_raw;
   frs_pins_s pins;

   assign pins_raw.frs_detect = frs_signal_pin;
   assign pins_raw.vbus_low = vbus_low_pin;
   assign pins_raw.src_good = src_good_pin;

   frs_sync u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pins_async(pins_raw),
      .pins_sync(pins)
   );

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   frs_seq_s seq_reg;
   frs_seq_s seq_next;
   logic err;

   always_comb begin
      seq_next = seq_reg;
      err = 1'b0;
      seq_next.gcrc_send = 1'b0;
      seq_next.swap_error = 1'b0;
      if (seq_reg.timer != `FRS_TIMER_RST) begin
         seq_next.timer = seq_reg.timer - 24'h1;
      end
      if (seq_reg.src_timer != `FRS_TIMER_RST) begin
         seq_next.src_timer = seq_reg.src_timer - 24'h1;
      end
      case (seq_reg.state)
         FRS_ST_IDLE: begin
            if (pins.frs_detect) begin
               seq_next.state = FRS_ST_TX_FRSWAP;
               seq_next.tx_valid = 1'b1;
               seq_next.tx_msg = FRS_MSG_FR_SWAP;
               seq_next.timer = INIT_LD;
            end
         end
         FRS_ST_TX_FRSWAP: begin
            if (tx_ack) begin
               seq_next.tx_valid = 1'b0;
               seq_next.tx_msg = FRS_MSG_NONE;
               seq_next.state = FRS_ST_WAIT_ACCEPT;
               seq_next.timer = RSP_LD;
            end else if (tx_nack || rx_valid || seq_reg.timer == 24'h1) begin
               err = 1'b1;
            end
         end
         FRS_ST_WAIT_ACCEPT: begin
            if (rx_valid) begin
               if (rx_msg == FRS_MSG_ACCEPT) begin
                  seq_next.gcrc_send = 1'b1;
                  seq_next.state = FRS_ST_TRANSIT;
                  seq_next.timer = RSP_LD;
               end else begin
                  err = 1'b1;
               end
            end else if (seq_reg.timer == 24'h1) begin
               err = 1'b1;
            end
         end
         FRS_ST_TRANSIT: begin
            if (pins.vbus_low && !seq_reg.vbus_low_seen) begin
               seq_next.vbus_low_seen = 1'b1;
               seq_next.vbus_src_en = 1'b1;
               seq_next.role_src = 1'b1;
               seq_next.src_timer = SRC_LD;
            end
            if (seq_reg.vbus_src_en && !seq_reg.src_on) begin
               if (pins.src_good) begin
                  seq_next.src_on = 1'b1;
               end else if (seq_reg.src_timer == 24'h1) begin
                  err = 1'b1;
               end
            end
            if (rx_valid) begin
               if (rx_msg == FRS_MSG_PS_RDY && !seq_reg.psrdy_rx) begin
                  seq_next.psrdy_rx = 1'b1;
                  seq_next.gcrc_send = 1'b1;
               end else begin
                  err = 1'b1;
               end
            end else if (!seq_reg.psrdy_rx && seq_reg.timer == 24'h1) begin
               err = 1'b1;
            end
            if (seq_reg.src_on && seq_reg.psrdy_rx) begin
               seq_next.state = FRS_ST_TX_PSRDY;
               seq_next.tx_valid = 1'b1;
               seq_next.tx_msg = FRS_MSG_PS_RDY;
               seq_next.cc_rp_en = 1'b1;
               seq_next.timer = ACK_LD;
            end
         end
         FRS_ST_TX_PSRDY: begin
            if (tx_ack) begin
               seq_next.tx_valid = 1'b0;
               seq_next.tx_msg = FRS_MSG_NONE;
               seq_next.negotiate_ok = 1'b1;
               seq_next.state = FRS_ST_SOURCE;
            end else if (tx_nack || rx_valid || seq_reg.timer == 24'h1) begin
               err = 1'b1;
            end
         end
         FRS_ST_SOURCE: begin
            seq_next.timer = `FRS_TIMER_RST;
         end
         default: begin
            err = 1'b1;
         end
      endcase
      if (err) begin
         seq_next = '0;
         seq_next.swap_error = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_reg <= '0;
      end else begin
         seq_reg <= seq_next;
      end
   end

   assign tx_valid = seq_reg.tx_valid;
   assign tx_msg = seq_reg.tx_msg;
   assign gcrc_send = seq_reg.gcrc_send;
   assign vbus_src_en = seq_reg.vbus_src_en;
   assign cc_rp_en = seq_reg.cc_rp_en;
   assign role_src = seq_reg.role_src;
   assign negotiate_ok = seq_reg.negotiate_ok;
   assign swap_error = seq_reg.swap_error;
   assign seq_state = seq_reg.state;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_frswap_on_detect: assert property (@(posedge core_clk) disable iff (!rst_n)
      (seq_reg.state == FRS_ST_IDLE && pins.frs_detect)
      |=> (tx_valid && tx_msg == FRS_MSG_FR_SWAP))
      else $error("FR_Swap not sent after swap signal");

   a_src_after_low: assert property (@(posedge core_clk) disable iff (!rst_n)
      (seq_reg.state == FRS_ST_TRANSIT && pins.vbus_low && !seq_reg.vbus_low_seen
       && !err)
      |=> (vbus_src_en && role_src))
      else $error("Supply not enabled after VBUS low");

   a_src_deadline: assert property (@(posedge core_clk) disable iff (!rst_n)
      (seq_reg.state == FRS_ST_TRANSIT && vbus_src_en && !seq_reg.src_on
       && seq_reg.src_timer == 24'h1 && !pins.src_good)
      |=> (seq_state == FRS_ST_IDLE && swap_error && !vbus_src_en))
      else $error("Supply deadline miss not handled");

   a_psrdy_needs_src: assert property (@(posedge core_clk) disable iff (!rst_n)
      (tx_valid && tx_msg == FRS_MSG_PS_RDY)
      |-> (vbus_src_en && seq_reg.src_on && seq_reg.psrdy_rx))
      else $error("PS_RDY sent before supply started");

   a_rp_with_psrdy: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(tx_valid && tx_msg == FRS_MSG_PS_RDY) |-> (cc_rp_en && !$past(cc_rp_en)))
      else $error("Rp not applied with PS_RDY");

   a_goodcrc_reply: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rx_valid && ((seq_reg.state == FRS_ST_WAIT_ACCEPT && rx_msg == FRS_MSG_ACCEPT)
       || (seq_reg.state == FRS_ST_TRANSIT && rx_msg == FRS_MSG_PS_RDY
       && !seq_reg.psrdy_rx)) && !err)
      |=> gcrc_send ##1 !gcrc_send)
      else $error("GoodCRC request missing");

   a_negotiate_late: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(negotiate_ok)
      |-> ($past(tx_ack) && $past(seq_reg.state) == FRS_ST_TX_PSRDY && cc_rp_en))
      else $error("Negotiation allowed before final PS_RDY");

   a_nack_to_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      (tx_valid && tx_nack && !tx_ack)
      |=> (seq_state == FRS_ST_IDLE && swap_error ##1 !swap_error))
      else $error("Missing ack did not return to idle");

   a_stray_msg: assert property (@(posedge core_clk) disable iff (!rst_n)
      (seq_reg.state == FRS_ST_WAIT_ACCEPT && rx_valid && rx_msg != FRS_MSG_ACCEPT)
      |=> (seq_state == FRS_ST_IDLE && !tx_valid && !cc_rp_en))
      else $error("Unexpected message not treated as error");

endmodule : frs_seq

`default_nettype wire

/* File: verification/frs_partner.sv */
/*
 Model of the old source port: its policy engine, both protocol layers and our supply.
 Assumes frs_seq on core_clk; every output changes 1 ns after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module frs_partner
   import frs_pkg::*;
(
   input wire logic core_clk,
   input wire logic tx_valid,
   input wire frs_msg_e tx_msg,
   input wire logic vbus_src_en,
   output logic frs_signal_pin,
   output logic vbus_low_pin,
   output logic src_good_pin,
   output logic tx_ack,
   output logic tx_nack,
   output logic rx_valid,
   output frs_msg_e rx_msg
);
   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic clr();
      frs_signal_pin = 1'b0;
      vbus_low_pin = 1'b0;
      src_good_pin = 1'b0;
      tx_ack = 1'b0;
      tx_nack = 1'b0;
      rx_valid = 1'b0;
      rx_msg = FRS_MSG_NONE;
   endtask : clr

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic send(input frs_msg_e m);
      rx_valid = 1'b1;
      rx_msg = m;
      tick(1);
      rx_valid = 1'b0;
      rx_msg = FRS_MSG_NONE;
   endtask : send

   task automatic ack_tx(input logic [1:0] d, input logic fail);
      int i;
      for (i = 0; i < 100 && tx_valid !== 1'b1; i++) tick(1);
      tick(int'(d) + 1);
      tx_ack = ~fail;
      tx_nack = fail;
      tick(1);
      tx_ack = 1'b0;
      tx_nack = 1'b0;
   endtask : ack_tx

   // ****************************************************************
   // Swap: 0 plain, 1 nack, 2 stray msg, 3 no ack, 4 no supply, 5 late PS_RDY
   // ****************************************************************
   task automatic swap(input int mode, input logic [11:0] r);
      int i;
      tick(1);
      frs_signal_pin = 1'b1;
      for (i = 0; i < 50 && tx_valid !== 1'b1; i++) tick(1);
      frs_signal_pin = 1'b0;
      if (mode == 3) return;
      ack_tx(r[1:0], mode == 1);
      if (mode == 1) return;
      tick(int'(r[4:2]) + 1);
      send(mode == 2 ? FRS_MSG_PS_RDY : FRS_MSG_ACCEPT);
      if (mode == 2) return;
      tick(int'(r[7:5]) + 1);
      vbus_low_pin = 1'b1;
      if (mode != 5) begin
         tick(int'(r[10:8]) + 1);
         send(FRS_MSG_PS_RDY);
      end
      for (i = 0; i < 100 && vbus_src_en !== 1'b1; i++) tick(1);
      tick(int'(r[11:9]) + 1 + 8 * int'(mode == 5));
      src_good_pin = (mode != 4);
      if (mode == 5) send(FRS_MSG_PS_RDY);
      if (mode != 4) ack_tx(r[3:2], 1'b0);
   endtask : swap
endmodule : frs_partner
`default_nettype wire

/* File: verification/tb.sv */
/*
 Self-checking bench of the fast role swap sequencer against the partner model.
 Assumes short timeout parameters so that each swap settles in a few hundred cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module tb
   import frs_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic tx_valid, gcrc_send, vbus_src_en, cc_rp_en, role_src, negotiate_ok, swap_error;
   logic frs_signal_pin, vbus_low_pin, src_good_pin, tx_ack, tx_nack, rx_valid;
   frs_msg_e tx_msg, rx_msg;
   frs_state_e seq_state;
   logic [3:0] exp_q[$];
   logic tv_q = 1'b0;
   logic [16:0] lf = 17'h176a1;
   int fcnt = 0, gcnt = 0, cyc = 0, error_cnt = 0, comparisons = 0, mode, i;

   initial forever #2 core_clk = ~core_clk;

   frs_seq #(.FRSWAP_INIT_CYC(20), .SRC_FRSWAP_CYC(40), .ACK_CYC(20), .RSP_CYC(60)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .frs_signal_pin(frs_signal_pin),
      .vbus_low_pin(vbus_low_pin), .src_good_pin(src_good_pin), .tx_ack(tx_ack),
      .tx_nack(tx_nack), .rx_valid(rx_valid), .rx_msg(rx_msg), .tx_valid(tx_valid),
      .tx_msg(tx_msg), .gcrc_send(gcrc_send), .vbus_src_en(vbus_src_en),
      .cc_rp_en(cc_rp_en), .role_src(role_src), .negotiate_ok(negotiate_ok),
      .swap_error(swap_error), .seq_state(seq_state));

   frs_partner p (
      .core_clk(core_clk), .tx_valid(tx_valid), .tx_msg(tx_msg), .vbus_src_en(vbus_src_en),
      .frs_signal_pin(frs_signal_pin), .vbus_low_pin(vbus_low_pin),
      .src_good_pin(src_good_pin), .tx_ack(tx_ack), .tx_nack(tx_nack),
      .rx_valid(rx_valid), .rx_msg(rx_msg));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : lfsr

   task automatic pop(input logic [3:0] got);
      logic [3:0] e;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 4'hf;
      `CHK("event", e, got)
   endtask : pop

   task automatic end_of_test();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test

   // ****************************************************************
   // Output watcher
   // ****************************************************************
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      tv_q <= tx_valid;
      fcnt <= frs_signal_pin ? fcnt + 1 : 0;
      gcnt <= gcnt + int'(gcrc_send === 1'b1);
      if (tx_valid === 1'b1 && tv_q === 1'b0) begin
         if (tx_msg === FRS_MSG_FR_SWAP) begin
            `CHK("fr_swap_delay", 1'b1, fcnt < 6)
            `CHK("rp_early", 1'b0, cc_rp_en)
         end else begin
            `CHK("supply_before_rdy", 1'b1, vbus_src_en)
            `CHK("rp_with_rdy", 1'b1, cc_rp_en)
            `CHK("early_nego", 1'b0, negotiate_ok)
         end
         pop({1'b0, tx_msg});
      end
      if (swap_error === 1'b1) begin
         `CHK("err_outputs", 1'b0, vbus_src_en | cc_rp_en | tx_valid | role_src)
         pop(4'h8);
      end
      if (cyc == 5000) begin
         error_cnt++;
         end_of_test();
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      p.clr();
      for (mode = 0; mode < 6; mode++) begin
         rst_n = 1'b0;
         p.clr();
         repeat (4) @(posedge core_clk);
         #1;
         rst_n = 1'b1;
         gcnt = 0;
         exp_q.push_back({1'b0, FRS_MSG_FR_SWAP});
         exp_q.push_back(mode inside {0, 5} ? {1'b0, FRS_MSG_PS_RDY} : 4'h8);
         lf = lfsr(lf);
         p.swap(mode, lf[11:0]);
         for (i = 0; i < 300 && exp_q.size() > 0; i++) @(posedge core_clk);
         repeat (2) @(posedge core_clk);
         #1;
         `CHK("queue_empty", 0, exp_q.size())
         `CHK("nego_ok", mode inside {0, 5}, negotiate_ok)
         `CHK("role_src", mode inside {0, 5}, role_src)
         `CHK("gcrc_cnt", (mode inside {0, 4, 5}) ? 2 : 0, gcnt)
         `CHK("cc_rp", mode inside {0, 5}, cc_rp_en)
         `CHK("state", (mode inside {0, 5}) ? FRS_ST_SOURCE : FRS_ST_IDLE, seq_state)
      end
      end_of_test();
   end
endmodule : tb
`default_nettype wire
